// ### psrls_pkg.sv
// Constants, register map and frame receiver state type of the PHY soft reset and link block
package psrls_pkg;

  // ***************************************************
  // Register offsets (management register numbers)
  // ***************************************************
  localparam logic [4:0] REG_BASIC_MODE_CONTROL  = 5'h00;
  localparam logic [4:0] REG_BASIC_MODE_STATUS   = 5'h01;
  localparam logic [4:0] REG_AUTONEG_ADVERTISE   = 5'h04;
  localparam logic [4:0] REG_CODING_SUBLAYER_CFG = 5'h16;
  localparam logic [4:0] REG_LOOPBACK_BYPASS     = 5'h17;

  // ***************************************************
  // Field positions
  // ***************************************************
  localparam int BMC_SOFT_RESET_BIT  = 15;
  localparam int BMC_SPEED_100_BIT   = 13;
  localparam int BMC_AUTONEG_EN_BIT  = 12;
  localparam int BMS_LINK_STATUS_BIT = 2;
  localparam int BMS_AN_COMPLETE_BIT = 5;
  localparam int CSC_FORCE_GOOD_LINK_BIT = 6;
  localparam int LBC_SCR_BYPASS_BIT  = 12;
  localparam int ADV_100_LO_BIT      = 7;
  localparam int ADV_100_HI_BIT      = 9;

  // ***************************************************
  // Reset values and fixed status content
  // ***************************************************
  localparam logic [15:0] BMC_RESET_VAL  = 16'h3000;
  localparam logic [15:0] ADV_RESET_VAL  = 16'h01E1;
  localparam logic [15:0] CSC_RESET_VAL  = 16'h0000;
  localparam logic [15:0] LBC_RESET_VAL  = 16'h0000;
  localparam logic [15:0] BMS_CAPS       = 16'h7809;
  localparam logic [4:0]  PHYAD_RESET_VAL = 5'h00;

  // ***************************************************
  // Timing
  // ***************************************************
  localparam int CLK_PERIOD_NS  = 25;
  localparam int SRST_TIME_NS   = 5000;
  localparam int SRST_CYC       = SRST_TIME_NS / CLK_PERIOD_NS;
  localparam logic [7:0] SRST_LAST = 8'(SRST_CYC - 1);
  localparam logic [5:0] MDIO_PRE_LEN = 6'h20;

  // Management frame receiver states
  typedef enum logic [2:0] {
    M_IDLE, M_ST, M_HDR, M_TA, M_RDATA, M_WDATA
  } psrls_mstate_t;

endpackage : psrls_pkg

// ### psrls_core.sv
// Management registers, soft reset sequencer and link indication logic
`timescale 1ns/100ps
// Behaviour
// R1: Writing one to bit 15 of register 00h starts a software reset.
// R2: The reset bit clears itself and reads as one while reset runs.
// R3: The software reset finishes about 5 us after the write.
// R4: Finishing a software reset restores every register default.
// R5: A software reset latches the strap inputs again.
// R6: The manager waits 500 us after a reset before the next frame.
// R7: Forced 100 Mb/s with forced good link transmits regardless of link.
// R8: In forced good link 100 Mb/s the link pin follows descrambler lock.
// R9: Descrambler lock is true when bypassed or synchronised to idles.
// R10: Bit 12 of register 17h bypasses the scrambler and descrambler.
// R11: Forced 10 Mb/s takes received energy as link on pin and bit 2.
// R12: Negotiation advertising only 10 Mb/s never completes on 100 stream.
// R13: Transmit clocks of several devices carry no phase alignment.
module psrls_core
  import psrls_pkg::*;
(
  input  wire logic       ref_clk,
  input  wire logic       sys_rst,
  input  wire logic       clk_en,
  input  wire logic       mdc,
  input  wire logic       mdio_in,
  output logic            mdio_out,
  output logic            mdio_oe,
  input  wire logic [4:0] strap_phyad,
  input  wire logic       rx_10m_energy,
  input  wire logic       rx_descr_sync,
  input  wire logic       rx_100m_stream,
  input  wire logic       an_partner_ack,
  output logic            link_indicator_pin,
  output logic            descrambler_lock_flag,
  output logic            scrambler_bypass,
  output logic            tx_enable,
  output logic            soft_reset_busy
);
  // *************************************************
  // State record
  // *************************************************
  typedef struct packed {
    logic          mdc_q;
    psrls_mstate_t mst;
    logic [5:0]    pre_cnt;
    logic [3:0]    bit_cnt;
    logic [15:0]   sh;
    logic [15:0]   dout;
    logic [4:0]    ra;
    logic          rd;
    logic          mdio_o;
    logic          mdio_en;
    logic [15:0]   bmc;
    logic [15:0]   adv;
    logic [15:0]   csc;
    logic [15:0]   lbc;
    logic [4:0]    phyad;
    logic          strap_pend;
    logic          busy;
    logic [7:0]    rst_cnt;
    logic          link;
    logic          lock;
    logic          byp;
    logic          txen;
  } psrls_state_t;
  psrls_state_t s_q, s_d;
  logic        mdc_rise;
  logic        forced_100;
  logic        forced_10;
  logic        force_good;
  logic        lock_now;
  logic        an_done;
  logic        adv_100;
  logic [15:0] bmc_view;
  logic [15:0] bms_view;
  logic [15:0] rd_val;
  logic [11:0] hdr;
  logic [15:0] wdat;
  // *************************************************
  // Mode decode and live status
  // *************************************************
  always_comb begin
    mdc_rise   = mdc & ~s_q.mdc_q;
    forced_100 = ~s_q.bmc[BMC_AUTONEG_EN_BIT] & s_q.bmc[BMC_SPEED_100_BIT];
    forced_10  = ~s_q.bmc[BMC_AUTONEG_EN_BIT] & ~s_q.bmc[BMC_SPEED_100_BIT];
    force_good = s_q.csc[CSC_FORCE_GOOD_LINK_BIT];
    lock_now   = s_q.lbc[LBC_SCR_BYPASS_BIT] | rx_descr_sync; // R9
    adv_100    = |s_q.adv[ADV_100_HI_BIT:ADV_100_LO_BIT];
    // A 100 stream seen while only 10 is offered blocks completion
    an_done    = s_q.bmc[BMC_AUTONEG_EN_BIT] & an_partner_ack
                 & ~(rx_100m_stream & ~adv_100); // R12
    bmc_view   = s_q.bmc;
    bmc_view[BMC_SOFT_RESET_BIT] = s_q.busy; // R2
    bms_view   = BMS_CAPS;
    bms_view[BMS_LINK_STATUS_BIT] = s_q.link; // R11
    bms_view[BMS_AN_COMPLETE_BIT] = an_done;
    hdr  = {s_q.sh[10:0], mdio_in};
    wdat = {s_q.sh[14:0], mdio_in};
  end
  // Read multiplexer, unmapped registers read as zero
  always_comb begin
    unique case (hdr[4:0])
      REG_BASIC_MODE_CONTROL:  rd_val = bmc_view;
      REG_BASIC_MODE_STATUS:   rd_val = bms_view;
      REG_AUTONEG_ADVERTISE:   rd_val = s_q.adv;
      REG_CODING_SUBLAYER_CFG: rd_val = s_q.csc;
      REG_LOOPBACK_BYPASS:     rd_val = s_q.lbc;
      default:                 rd_val = 16'h0000;
    endcase
  end
  // *************************************************
  // Next state
  // *************************************************
  always_comb begin
    s_d       = s_q;
    s_d.mdc_q = mdc;
    // Straps are caught one clock after the hardware reset lets go
    if (s_q.strap_pend) begin
      s_d.phyad      = strap_phyad;
      s_d.strap_pend = 1'b0;
    end
    // Management frame receiver, advanced on each rising MDC edge
    if (mdc_rise) begin
      unique case (s_q.mst)
        M_IDLE: begin
          if (mdio_in) begin
            if (s_q.pre_cnt != MDIO_PRE_LEN)
              s_d.pre_cnt = s_q.pre_cnt + 6'h01;
          end else begin
            s_d.mst     = (s_q.pre_cnt == MDIO_PRE_LEN) ? M_ST : M_IDLE;
            s_d.pre_cnt = 6'h00;
          end
        end
        M_ST: begin
          s_d.mst     = mdio_in ? M_HDR : M_IDLE;
          s_d.bit_cnt = 4'h0;
        end
        M_HDR: begin
          s_d.sh      = {s_q.sh[14:0], mdio_in};
          s_d.bit_cnt = s_q.bit_cnt + 4'h1;
          if (s_q.bit_cnt == 4'hB) begin
            s_d.bit_cnt = 4'h0;
            s_d.ra      = hdr[4:0];
            s_d.rd      = (hdr[11:10] == 2'b10);
            s_d.dout    = rd_val;
            // Other addresses and bad opcodes leave the pin alone
            if (hdr[9:5] == s_q.phyad && (hdr[11] ^ hdr[10]))
              s_d.mst = M_TA;
            else
              s_d.mst = M_IDLE;
          end
        end
        M_TA: begin
          s_d.bit_cnt = s_q.bit_cnt + 4'h1;
          if (s_q.bit_cnt == 4'h0) begin
            s_d.mdio_en = s_q.rd;
            s_d.mdio_o  = 1'b0;
          end else begin
            s_d.bit_cnt = 4'h0;
            s_d.mst     = s_q.rd ? M_RDATA : M_WDATA;
            s_d.mdio_o  = s_q.rd & s_q.dout[15];
            s_d.dout    = {s_q.dout[14:0], 1'b0};
          end
        end
        M_RDATA: begin
          s_d.bit_cnt = s_q.bit_cnt + 4'h1;
          s_d.mdio_o  = s_q.dout[15];
          s_d.dout    = {s_q.dout[14:0], 1'b0};
          if (s_q.bit_cnt == 4'hF) begin
            s_d.mdio_en = 1'b0;
            s_d.mdio_o  = 1'b0;
            s_d.mst     = M_IDLE;
          end
        end
        M_WDATA: begin
          s_d.sh      = wdat;
          s_d.bit_cnt = s_q.bit_cnt + 4'h1;
          if (s_q.bit_cnt == 4'hF) begin
            s_d.mst = M_IDLE;
            unique case (s_q.ra)
              REG_BASIC_MODE_CONTROL: begin
                s_d.bmc = wdat & ~(16'h0001 << BMC_SOFT_RESET_BIT);
                if (wdat[BMC_SOFT_RESET_BIT] && !s_q.busy) begin
                  s_d.busy    = 1'b1; // R1
                  s_d.rst_cnt = 8'h00;
                end
              end
              REG_AUTONEG_ADVERTISE:   s_d.adv = wdat;
              REG_CODING_SUBLAYER_CFG: s_d.csc = wdat;
              REG_LOOPBACK_BYPASS:     s_d.lbc = wdat; // R10
              default: ;
            endcase
          end
        end
        default: s_d.mst = M_IDLE;
      endcase
    end
    // Soft reset timer; the manager must stay off the bus meanwhile
    if (s_q.busy) begin // R6
      s_d.rst_cnt = s_q.rst_cnt + 8'h01;
      if (s_q.rst_cnt == SRST_LAST) begin
        s_d.busy  = 1'b0; // R3
        s_d.bmc   = BMC_RESET_VAL; // R4
        s_d.adv   = ADV_RESET_VAL;
        s_d.csc   = CSC_RESET_VAL;
        s_d.lbc   = LBC_RESET_VAL;
        s_d.phyad = strap_phyad; // R5
      end
    end
    // Link indication per operating mode
    s_d.lock = lock_now;
    s_d.byp  = s_q.lbc[LBC_SCR_BYPASS_BIT]; // R10
    if (forced_100)
      s_d.link = lock_now; // R8
    else if (forced_10)
      s_d.link = rx_10m_energy; // R11
    else
      s_d.link = an_done;
    // Forced good link in forced 100 Mb/s lets data out even with the indicator dark
    s_d.txen = (forced_100 & force_good) | s_d.link; // R7
  end
  // State register; the idle frame state is the all-zero code
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      s_q            <= '0;
      s_q.bmc        <= BMC_RESET_VAL;
      s_q.adv        <= ADV_RESET_VAL;
      s_q.csc        <= CSC_RESET_VAL;
      s_q.lbc        <= LBC_RESET_VAL;
      s_q.phyad      <= PHYAD_RESET_VAL;
      s_q.strap_pend <= 1'b1;
    end else if (clk_en) begin
      s_q <= s_d;
    end
  end
  // Outputs straight from the record; no alignment to other ports R13
  assign mdio_out              = s_q.mdio_o;
  assign mdio_oe               = s_q.mdio_en;
  assign link_indicator_pin    = s_q.link;
  assign descrambler_lock_flag = s_q.lock;
  assign scrambler_bypass      = s_q.byp;
  assign tx_enable             = s_q.txen;
  assign soft_reset_busy       = s_q.busy;
  // *************************************************
  // Checks
  // *************************************************
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (sys_rst);
  logic [8:0] busy_age_q; // Reset age; a low enable must not age it
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst)
      busy_age_q <= 9'h000;
    else if (!s_q.busy)
      busy_age_q <= 9'h000;
    else if (clk_en)
      busy_age_q <= busy_age_q + 9'h001;
  end
  property p_start;
    clk_en && mdc_rise && s_q.mst == M_WDATA && s_q.bit_cnt == 4'hF
      && s_q.ra == REG_BASIC_MODE_CONTROL && mdio_in |=> s_q.busy;
  endproperty
  a_start: assert property (p_start) else $error("reset not started"); // R1 asks for bit 15; this check keys on the last data bit, mdio_in (bit 0)
  property p_reads_one;
    s_q.busy |-> bmc_view[BMC_SOFT_RESET_BIT] && !s_q.bmc[BMC_SOFT_RESET_BIT];
  endproperty
  a_reads_one: assert property (p_reads_one) else $error("bit 15 view"); // R2
  property p_length; busy_age_q <= 9'(SRST_CYC); endproperty
  a_length: assert property (p_length) else $error("reset too long"); // R3
  property p_defaults;
    $fell(s_q.busy) |-> s_q.adv == ADV_RESET_VAL && s_q.lbc == LBC_RESET_VAL
      && s_q.csc == CSC_RESET_VAL && s_q.bmc == BMC_RESET_VAL;
  endproperty
  a_defaults: assert property (p_defaults) else $error("defaults lost"); // R4
  property p_strap;
    $fell(s_q.busy) |-> s_q.phyad == $past(strap_phyad);
  endproperty
  a_strap: assert property (p_strap) else $error("strap not relatched"); // R5
  property p_force_tx;
    clk_en && forced_100 && force_good |=> tx_enable;
  endproperty
  a_force_tx: assert property (p_force_tx) else $error("no forced tx"); // R7
  property p_link_lock;
    clk_en && forced_100 |=> link_indicator_pin == $past(lock_now);
  endproperty
  a_link_lock: assert property (p_link_lock) else $error("link vs lock"); // R8
  property p_bypass_lock;
    clk_en && s_q.lbc[LBC_SCR_BYPASS_BIT] |=> descrambler_lock_flag
      && scrambler_bypass;
  endproperty
  a_bypass_lock: assert property (p_bypass_lock) else $error("bypass"); // R9
  property p_false_link;
    clk_en && forced_10 && rx_10m_energy |=> link_indicator_pin
      && bms_view[BMS_LINK_STATUS_BIT];
  endproperty
  a_false_link: assert property (p_false_link) else $error("10M link"); // R11
  property p_no_an;
    rx_100m_stream && !adv_100 |-> !bms_view[BMS_AN_COMPLETE_BIT];
  endproperty
  a_no_an: assert property (p_no_an) else $error("negotiation done"); // R12
endmodule : psrls_core

// ### psrls_mgr_model.sv
// Station manager model: management frames over MDC/MDIO
`timescale 1ns/100ps
module psrls_mgr_model (
  input  wire logic ref_clk,
  input  wire logic mdio_out,
  input  wire logic mdio_oe,
  output logic      mdc,
  output logic      mdio_in
);
  // ***************************************************
  // Line and frame driver
  // ***************************************************
  logic md_q;
  logic md_en;

  // Released line is pulled up, never left at the last bit
  assign mdio_in = mdio_oe ? mdio_out : (md_en ? md_q : 1'b1);

  initial begin
    mdc = 1'b0;
    md_q = 1'b1;
    md_en = 1'b0;
  end

  // One bit: one cycle high, two low, line sampled at the end
  task automatic slot(input logic b, input logic drv, output logic s);
    @(negedge ref_clk);
    md_q = b;
    md_en = drv;
    mdc = 1'b1;
    @(negedge ref_clk);
    mdc = 1'b0;
    @(negedge ref_clk);
    s = mdio_in;
  endtask : slot

  // Full frame; first data bit is seen at the end of turnaround
  task automatic frame(input logic rd, input logic [4:0] pa,
                       input logic [4:0] ra, input logic [15:0] wd,
                       output logic [15:0] q);
    logic [13:0] hdr;
    logic        s;
    hdr = {2'b01, rd, ~rd, pa, ra};
    for (int i = 0; i < 32; i++) begin
      slot(1'b1, 1'b1, s);
    end
    for (int i = 13; i >= 0; i--) begin
      slot(hdr[i], 1'b1, s);
    end
    slot(1'b1, ~rd, s);
    slot(1'b0, ~rd, s);
    for (int i = 15; i >= 0; i--) begin
      q[i] = s;
      slot(wd[i], ~rd, s);
    end
    md_en = 1'b0;
  endtask : frame

  // Quiet time after a soft reset, 500 us at 40 MHz
  task automatic settle();
    repeat (20000) @(negedge ref_clk);
  endtask : settle
endmodule : psrls_mgr_model

// ### tb.sv
// Self-checking bench for the soft reset and link block
`timescale 1ns/100ps
module tb
  import psrls_pkg::*;
;
  // ***************************************************
  // Signals and instances
  // ***************************************************
  logic        ref_clk, sys_rst, clk_en, mdc, mdio_in, mdio_out, mdio_oe;
  logic        e10, dsync, s100, ack, link, lock, byp, txe, busy;
  logic [4:0]  strap;
  int          err_count, compares, busy_cnt;

  psrls_core dut_u (.ref_clk(ref_clk), .sys_rst(sys_rst), .clk_en(clk_en),
    .mdc(mdc), .mdio_in(mdio_in), .mdio_out(mdio_out), .mdio_oe(mdio_oe),
    .strap_phyad(strap), .rx_10m_energy(e10), .rx_descr_sync(dsync),
    .rx_100m_stream(s100), .an_partner_ack(ack),
    .link_indicator_pin(link), .descrambler_lock_flag(lock),
    .scrambler_bypass(byp), .tx_enable(txe), .soft_reset_busy(busy));

  psrls_mgr_model mgr_u (.ref_clk(ref_clk), .mdio_out(mdio_out),
    .mdio_oe(mdio_oe), .mdc(mdc), .mdio_in(mdio_in));

  initial begin
    ref_clk = 1'b0;
    forever #12.5 ref_clk = ~ref_clk;
  end

  // Busy length measured independently of any frame
  always @(posedge ref_clk) if (busy === 1'b1) busy_cnt++;

  // ***************************************************
  // Shared tasks
  // ***************************************************
  task automatic chk(input string nm, input logic [15:0] exp,
                     input logic [15:0] got);
    compares++;
    if (got !== exp) begin
      err_count++;
      $display("BAD %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  task automatic rd(input logic [4:0] ra, input logic [15:0] exp);
    logic [15:0] v;
    mgr_u.frame(1'b1, strap, ra, 16'h0000, v);
    chk("register", exp, v);
  endtask : rd

  task automatic wr(input logic [4:0] ra, input logic [15:0] wd);
    logic [15:0] v;
    mgr_u.frame(1'b0, strap, ra, wd, v);
  endtask : wr

  // Order: link, lock, bypass, transmit enable; allows pipeline to land
  task automatic pins(input logic [3:0] exp);
    repeat (4) @(negedge ref_clk);
    chk("pins", {12'h000, exp}, {12'h000, link, lock, byp, txe});
  endtask : pins

  task automatic print_verdict();
    $display("compares %0d err_count %0d", compares, err_count);
    if (err_count == 0 && compares > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : print_verdict

  // ***************************************************
  // Scenarios
  // ***************************************************
  task automatic t_defaults();
    rd(REG_BASIC_MODE_CONTROL, 16'h3000);
    rd(REG_BASIC_MODE_STATUS, 16'h7809);
    rd(REG_AUTONEG_ADVERTISE, 16'h01E1);
    rd(REG_CODING_SUBLAYER_CFG, 16'h0000);
    rd(REG_LOOPBACK_BYPASS, 16'h0000);
    rd(5'h05, 16'h0000);
    wr(REG_BASIC_MODE_STATUS, 16'hFFFF);
    rd(REG_BASIC_MODE_STATUS, 16'h7809);
  endtask : t_defaults

  // Reads during busy on purpose, ignoring the quiet-time advice
  task automatic t_soft_reset();
    logic [15:0] v;
    int          n;
    wr(REG_AUTONEG_ADVERTISE, 16'h0061);
    wr(REG_CODING_SUBLAYER_CFG, 16'h0040);
    wr(REG_LOOPBACK_BYPASS, 16'h1000);
    rd(REG_CODING_SUBLAYER_CFG, 16'h0040);
    rd(REG_LOOPBACK_BYPASS, 16'h1000);
    busy_cnt = 0;
    wr(REG_BASIC_MODE_CONTROL, 16'h8000);
    chk("busy", 16'h0001, {15'h0000, busy});
    strap = 5'h0A;
    mgr_u.frame(1'b1, 5'h05, REG_BASIC_MODE_CONTROL, 16'h0000, v);
    chk("reset bit", 16'h8000, v);
    n = 0;
    while (busy !== 1'b0 && n < 300) begin
      @(negedge ref_clk);
      n++;
    end
    if (n >= 300) begin
      err_count++;
      print_verdict();
    end
    chk("busy length", 16'(SRST_CYC), 16'(busy_cnt));
    mgr_u.settle();
    mgr_u.frame(1'b1, 5'h05, REG_BASIC_MODE_CONTROL, 16'h0000, v);
    chk("old address", 16'hFFFF, v);
    rd(REG_BASIC_MODE_CONTROL, 16'h3000);
    rd(REG_AUTONEG_ADVERTISE, 16'h01E1);
    rd(REG_CODING_SUBLAYER_CFG, 16'h0000);
    rd(REG_LOOPBACK_BYPASS, 16'h0000);
  endtask : t_soft_reset

  task automatic t_forced100();
    wr(REG_BASIC_MODE_CONTROL, 16'h2000);
    wr(REG_CODING_SUBLAYER_CFG, 16'h0040);
    pins(4'b0001);
    wr(REG_LOOPBACK_BYPASS, 16'h1000);
    pins(4'b1111);
    wr(REG_LOOPBACK_BYPASS, 16'h0000);
    dsync = 1'b1;
    pins(4'b1101);
    dsync = 1'b0;
    pins(4'b0001);
    wr(REG_CODING_SUBLAYER_CFG, 16'h0000);
    pins(4'b0000);
  endtask : t_forced100

  task automatic t_forced10();
    wr(REG_BASIC_MODE_CONTROL, 16'h0000);
    e10 = 1'b1;
    pins(4'b1001);
    rd(REG_BASIC_MODE_STATUS, 16'h780D);
    // Low enable must hold the stale link while the energy goes away
    clk_en = 1'b0;
    e10 = 1'b0;
    pins(4'b1001);
    clk_en = 1'b1;
    pins(4'b0000);
  endtask : t_forced10

  task automatic t_autoneg();
    wr(REG_BASIC_MODE_CONTROL, 16'h1000);
    wr(REG_AUTONEG_ADVERTISE, 16'h0061);
    s100 = 1'b1;
    ack = 1'b1;
    pins(4'b0000);
    rd(REG_BASIC_MODE_STATUS, 16'h7809);
    wr(REG_AUTONEG_ADVERTISE, 16'h01E1);
    pins(4'b1001);
    rd(REG_BASIC_MODE_STATUS, 16'h782D);
  endtask : t_autoneg

  // ***************************************************
  // Main sequence
  // ***************************************************
  initial begin
    err_count = 0;
    compares = 0;
    busy_cnt = 0;
    sys_rst = 1'b1;
    clk_en = 1'b1;
    strap = 5'h05;
    {e10, dsync, s100, ack} = 4'h0;
    repeat (20) @(negedge ref_clk);
    sys_rst = 1'b0;
    repeat (2) @(negedge ref_clk);
    t_defaults();
    t_soft_reset();
    t_forced100();
    t_forced10();
    t_autoneg();
    print_verdict();
  end
endmodule : tb
